// ==== design/fsw_pkg.sv ====
package fsw_pkg;
  // Status word bit positions
  localparam int FSW_WIP = 0;
  localparam int FSW_WEL = 1;
  localparam int FSW_BP_LO = 2;
  localparam int FSW_BP_HI = 6;
  localparam int FSW_STATUS_LOCK_SEL_LO = 7;
  localparam int FSW_STATUS_LOCK_SEL_HI = 8;
  localparam int FSW_QE = 9;
  localparam int FSW_PSUS = 10;
  localparam int FSW_LB_LO = 11;
  localparam int FSW_LB_HI = 13;
  localparam int FSW_CMP = 14;
  localparam int FSW_ESUS = 15;
  // Power-up values of the stored fields
  localparam logic [4:0] FSW_BP_RST = 5'h00;
  localparam logic FSW_CMP_RST = 1'b0;
  localparam logic FSW_QE_RST = 1'b0;
  localparam logic [2:0] FSW_LB_RST = 3'h0;
  localparam logic [1:0] FSW_SRP_RST = 2'h0;
  // Command codes
  localparam logic [7:0] FSW_C_SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] FSW_C_CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] FSW_C_WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] FSW_C_PROG = 8'h02;
  localparam logic [7:0] FSW_C_QPROG = 8'h32;
  localparam logic [7:0] FSW_C_SECT = 8'h20;
  localparam logic [7:0] FSW_C_BLK32 = 8'h52;
  localparam logic [7:0] FSW_C_BLK64 = 8'hd8;
  localparam logic [7:0] FSW_C_CHIP1 = 8'h60;
  localparam logic [7:0] FSW_C_CHIP2 = 8'hc7;
  localparam logic [7:0] FSW_C_SUSP = 8'h75;
  localparam logic [7:0] FSW_C_RESUME = 8'h7a;
  localparam logic [7:0] FSW_C_RSTEN = 8'h66;
  localparam logic [7:0] FSW_C_RST = 8'h99;
  // Protection region sizing, as address bit counts
  localparam logic [4:0] FSW_BIG_K0 = 5'h10;
  localparam logic [4:0] FSW_SMALL_K0 = 5'h0b;
  localparam logic [4:0] FSW_SMALL_KMAX = 5'h0f;
  localparam logic [4:0] FSW_SECT_K = 5'h0c;
  localparam logic [4:0] FSW_BLK32_K = 5'h0f;
  localparam logic [4:0] FSW_BLK64_K = 5'h10;
  // Status write duration
  localparam int FSW_CLK_NS = 10;
  localparam int FSW_SRW_NS = 10000;
  localparam int FSW_SRW_CYC = (FSW_SRW_NS + FSW_CLK_NS - 1) / FSW_CLK_NS;
  localparam logic [11:0] FSW_SRW_CNT = 12'(FSW_SRW_CYC);

  typedef enum logic [2:0] {FSW_OP_PROG, FSW_OP_SECT, FSW_OP_BLK32, FSW_OP_BLK64,
    FSW_OP_CHIP} fsw_op_kind_t;
  typedef enum {FSW_IDLE, FSW_ARRAY, FSW_SRWR, FSW_SUSP} fsw_state_t;
  typedef struct packed {
    logic [7:0] code;
    logic [23:0] addr;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic two_bytes;
    logic byte_ok;
  } fsw_cmd_t;
  typedef struct packed {
    fsw_op_kind_t kind;
    logic [23:0] addr;
  } fsw_op_t;
endpackage

// ==== design/fsw_status_protect.sv ====
// Notes on behaviour
// - Busy bit is 1 during program, erase or status write, else 0.
// - With write latch clear, status writes, programs and erases are refused.
// - Block-protect field is stored and changed only by a status write.
// - Block-protect writes are blocked while hardware status lock is active.
// - Programs and erases hitting the protected region are rejected.
// - Chip erase runs only with protect bits 2..0 all equal to complement bit.
// - Complement set: 000 protects everything, 111 protects nothing.
// - Complement set inverts the region chosen with complement clear.
// - Complement bit is stored at bit 14 and starts cleared.
// - High byte holds erase-suspend, complement, locks, program-suspend, quad, lock-hi.
// - Lock select 00: status writes allowed once write latch is set.
// - Lock select 01: pin low locks status unless quad is on; pin high allows with latch.
// - Lock select 10: status locked until power cycle, which returns 00.
// - Lock select 11: status writes refused forever.
// - Quad enable 0 keeps protect/hold pins; 1 makes them quad data lines.
// - Three security lock bits at 13..11 are set-only and default 0.
// - Suspend sets erase or program suspended flag by what was suspended.
// - Resume, software reset pair or power cycle clear both suspend flags.
// - Write latch set by its command, cleared by disable, writes and power-up.
// - Complement clear: 000 protects nothing, 111 protects whole array.
module fsw_status_protect (
  // Core clock and power-up reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link side, on the serial clock
  input wire logic sclk,
  input wire logic cmd_strobe,
  input wire fsw_pkg::fsw_cmd_t cmd,
  output logic [15:0] status_rd,
  // Pins
  input wire logic write_protect_n,
  output logic quad_io_en,
  // Stored image and array datapath
  input wire logic [15:0] nv_image,
  output logic nv_store,
  output logic [15:0] nv_data,
  output logic op_start,
  output fsw_pkg::fsw_op_t op_req,
  output logic op_suspend,
  output logic op_resume,
  output logic op_abort,
  input wire logic op_done,
  output logic [2:0] secreg_ro
);
  import fsw_pkg::*;

  function automatic logic prot_hit(input logic [22:0] a, input logic [4:0] bp,
                                    input logic cmp);
    logic [4:0] k;
    logic [22:0] m;
    logic hit;
    k = bp[4] ? ((bp[2:0] > 3'h4) ? FSW_SMALL_KMAX : 5'(FSW_SMALL_K0 + bp[2:0]))
              : 5'(FSW_BIG_K0 + bp[2:0]);
    m = ~((23'h1 << k) - 23'h1);
    if (bp[2:0] == 3'h0) hit = 1'b0;
    else if (bp[2:0] == 3'h7) hit = 1'b1;
    else hit = bp[3] ? ((a & m) == 23'h0) : ((a & m) == m);
    return hit ^ cmp;
  endfunction

  // Regions sit at one end of the array, so an aligned unit overlaps one
  // exactly when its first or last byte is inside it.
  function automatic logic unit_hit(input logic [22:0] a, input logic [4:0] k,
                                    input logic [4:0] bp, input logic cmp);
    logic [22:0] lsb;
    lsb = (23'h1 << k) - 23'h1;
    return prot_hit(a & ~lsb, bp, cmp) | prot_hit(a | lsb, bp, cmp);
  endfunction

  // Reset synchronisers
  logic rs1_r, rst_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) {rs1_r, rst_sync} <= 2'b00;
    else {rs1_r, rst_sync} <= {1'b1, rs1_r};
  end
  logic ss1_r, srst_sync;
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) {ss1_r, srst_sync} <= 2'b00;
    else {ss1_r, srst_sync} <= {1'b1, ss1_r};
  end

  // Serial side: hold one command until the core acknowledges it
  fsw_cmd_t hold_r;
  logic req_tgl_r, ack_s1, ack_s2, ack_tgl_r;
  logic pt_s1, pt_s2, pt_s3, pak_tgl_r, pub_tgl_r;
  logic [15:0] pub_r, status_rd_r;
  wire link_free = (req_tgl_r == ack_s2);
  always_ff @(posedge sclk or negedge srst_sync) begin
    if (!srst_sync) begin
      hold_r <= '0;
      req_tgl_r <= 1'b0;
      {ack_s1, ack_s2} <= 2'b00;
      {pt_s1, pt_s2, pt_s3} <= 3'h0;
      pak_tgl_r <= 1'b0;
      status_rd_r <= 16'h0000;
    end else begin
      {ack_s1, ack_s2} <= {ack_tgl_r, ack_s1};
      {pt_s1, pt_s2, pt_s3} <= {pub_tgl_r, pt_s1, pt_s2};
      // A command arriving while the previous one is unacknowledged is lost;
      // the core answers within a few core cycles, far inside one byte time.
      if (cmd_strobe && link_free) begin
        hold_r <= cmd;
        req_tgl_r <= ~req_tgl_r;
      end
      // The status copy only refreshes while the serial clock runs
      if (pt_s2 != pt_s3) begin
        status_rd_r <= pub_r;
        pak_tgl_r <= pt_s2;
      end
    end
  end
  assign status_rd = status_rd_r;

  // Core side synchronisers
  logic rq_s1, rq_s2, rq_s3, pk_s1, pk_s2, wp_s1, wp_s2;
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      {rq_s1, rq_s2, rq_s3} <= 3'h0;
      {pk_s1, pk_s2} <= 2'b00;
      {wp_s1, wp_s2} <= 2'b11;
    end else begin
      {rq_s1, rq_s2, rq_s3} <= {req_tgl_r, rq_s1, rq_s2};
      {pk_s1, pk_s2} <= {pak_tgl_r, pk_s1};
      {wp_s1, wp_s2} <= {write_protect_n, wp_s1};
    end
  end

  // Core state
  fsw_state_t state_r, state_nxt;
  logic wel_r, status_lock_sel_lo_r, status_lock_sel_hi_r, qe_r, cmp_r, esus_r, psus_r, nv_ld_r, arm_r;
  logic [4:0] bp_r;
  logic [2:0] lb_r;
  logic [11:0] cnt_r;
  logic op_start_r, op_susp_r, op_res_r, op_abort_r, nv_store_r;
  fsw_op_t op_req_r;
  logic [15:0] nv_data_r;

  wire cmd_new = (rq_s2 != rq_s3) && nv_ld_r;
  wire [7:0] code = hold_r.code;
  wire fmt_ok = hold_r.byte_ok;
  wire busy = (state_r == FSW_ARRAY) || (state_r == FSW_SRWR);
  wire [22:0] addr = hold_r.addr[22:0];
  wire [1:0] srp = {status_lock_sel_hi_r, status_lock_sel_lo_r};
  wire is_prog = (code == FSW_C_PROG) || ((code == FSW_C_QPROG) && qe_r);
  wire is_sect = (code == FSW_C_SECT);
  wire is_b32 = (code == FSW_C_BLK32);
  wire is_b64 = (code == FSW_C_BLK64);
  wire is_chip = (code == FSW_C_CHIP1) || (code == FSW_C_CHIP2);
  wire is_array = is_prog || is_sect || is_b32 || is_b64 || is_chip;
  wire is_write_status_cmd = (code == FSW_C_WRITE_STATUS_CMD);
  // While quad is on the protect pin is a data line and cannot lock
  wire hw_lock = (srp == 2'h1) && !wp_s2 && !qe_r;
  wire sr_open = (srp == 2'h0) || ((srp == 2'h1) && !hw_lock);
  wire chip_ok = ((bp_r[2:0] == 3'h0) && !cmp_r) || ((bp_r[2:0] == 3'h7) && cmp_r);
  wire [4:0] unit_k = is_sect ? FSW_SECT_K : (is_b32 ? FSW_BLK32_K : FSW_BLK64_K);
  wire blocked = is_chip ? !chip_ok
               : (is_prog ? prot_hit(addr, bp_r, cmp_r)
                          : unit_hit(addr, unit_k, bp_r, cmp_r));
  wire take_wr = cmd_new && fmt_ok && wel_r && (state_r == FSW_IDLE);
  wire do_write_status_cmd = take_wr && is_write_status_cmd && sr_open;
  wire do_array = take_wr && is_array && !blocked;
  wire do_susp = cmd_new && (code == FSW_C_SUSP) && (state_r == FSW_ARRAY);
  wire do_res = cmd_new && (code == FSW_C_RESUME) && (state_r == FSW_SUSP);
  wire do_srst = cmd_new && (code == FSW_C_RST) && arm_r;
  wire susp_prog = (op_req_r.kind == FSW_OP_PROG);
  wire srw_end = (state_r == FSW_SRWR) && (cnt_r == 12'h000);
  wire [15:0] stat_w = {esus_r, cmp_r, lb_r, psus_r, qe_r, status_lock_sel_hi_r,
                        status_lock_sel_lo_r, bp_r, wel_r, busy};
  fsw_op_kind_t kind_sel;
  assign kind_sel = is_prog ? FSW_OP_PROG : is_sect ? FSW_OP_SECT
                  : is_b32 ? FSW_OP_BLK32 : is_b64 ? FSW_OP_BLK64 : FSW_OP_CHIP;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FSW_IDLE: begin
        if (do_array) state_nxt = FSW_ARRAY;
        else if (do_write_status_cmd) state_nxt = FSW_SRWR;
      end
      FSW_ARRAY: begin
        if (do_susp) state_nxt = FSW_SUSP;
        else if (op_done) state_nxt = FSW_IDLE;
      end
      FSW_SRWR: if (srw_end) state_nxt = FSW_IDLE;
      FSW_SUSP: begin
        if (do_res) state_nxt = FSW_ARRAY;
        else if (do_srst) state_nxt = FSW_IDLE;
      end
      default: state_nxt = FSW_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state_r <= FSW_IDLE;
      cnt_r <= 12'h000;
      arm_r <= 1'b0;
      nv_ld_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      nv_ld_r <= 1'b1;
      if (do_write_status_cmd) cnt_r <= FSW_SRW_CNT - 12'h001;
      else if (cnt_r != 12'h000) cnt_r <= cnt_r - 12'h001;
      if (cmd_new) arm_r <= fmt_ok && (code == FSW_C_RSTEN);
    end
  end

  // Write latch; power-up clears it
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) wel_r <= 1'b0;
    else if (cmd_new && fmt_ok && (code == FSW_C_SET_WRITE_LATCH_CMD) && !busy) wel_r <= 1'b1;
    else if (cmd_new && fmt_ok && (code == FSW_C_CLEAR_WRITE_LATCH_CMD) && !busy) wel_r <= 1'b0;
    else if (take_wr && (is_write_status_cmd || is_array)) wel_r <= 1'b0;
  end

  // Stored fields: loaded once after reset release, then only by a status write
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      bp_r <= FSW_BP_RST;
      cmp_r <= FSW_CMP_RST;
      qe_r <= FSW_QE_RST;
      lb_r <= FSW_LB_RST;
      {status_lock_sel_hi_r, status_lock_sel_lo_r} <= FSW_SRP_RST;
    end else if (!nv_ld_r) begin
      bp_r <= nv_image[FSW_BP_HI:FSW_BP_LO];
      cmp_r <= nv_image[FSW_CMP];
      qe_r <= nv_image[FSW_QE];
      lb_r <= nv_image[FSW_LB_HI:FSW_LB_LO];
      // Supply lock-down does not survive a power cycle
      if (nv_image[FSW_STATUS_LOCK_SEL_HI] && !nv_image[FSW_STATUS_LOCK_SEL_LO]) {status_lock_sel_hi_r, status_lock_sel_lo_r} <= 2'h0;
      else {status_lock_sel_hi_r, status_lock_sel_lo_r} <= {nv_image[FSW_STATUS_LOCK_SEL_HI], nv_image[FSW_STATUS_LOCK_SEL_LO]};
    end else if (do_write_status_cmd) begin
      // Busy, latch and suspend bits are never taken from the data
      bp_r <= hold_r.data_lo[FSW_BP_HI:FSW_BP_LO];
      status_lock_sel_lo_r <= hold_r.data_lo[FSW_STATUS_LOCK_SEL_LO];
      if (hold_r.two_bytes) begin
        status_lock_sel_hi_r <= hold_r.data_hi[FSW_STATUS_LOCK_SEL_HI-8];
        qe_r <= hold_r.data_hi[FSW_QE-8];
        cmp_r <= hold_r.data_hi[FSW_CMP-8];
        lb_r <= lb_r | hold_r.data_hi[FSW_LB_HI-8:FSW_LB_LO-8];
      end
    end
  end

  // Suspend flags
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) {esus_r, psus_r} <= 2'b00;
    else if (do_susp) {esus_r, psus_r} <= {!susp_prog, susp_prog};
    else if (do_res || do_srst) {esus_r, psus_r} <= 2'b00;
  end

  // Datapath strobes and store
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      op_start_r <= 1'b0;
      op_susp_r <= 1'b0;
      op_res_r <= 1'b0;
      op_abort_r <= 1'b0;
      op_req_r <= '{kind: FSW_OP_PROG, addr: 24'h000000};
      nv_store_r <= 1'b0;
      nv_data_r <= 16'h0000;
    end else begin
      op_start_r <= do_array;
      op_susp_r <= do_susp;
      op_res_r <= do_res;
      op_abort_r <= do_srst && (state_r == FSW_SUSP);
      if (do_array) op_req_r <= '{kind: kind_sel, addr: hold_r.addr};
      nv_store_r <= srw_end;
      if (srw_end) nv_data_r <= stat_w;
    end
  end

  // Publish status and answer commands toward the serial side
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pub_r <= 16'h0000;
      pub_tgl_r <= 1'b0;
      ack_tgl_r <= 1'b0;
    end else begin
      ack_tgl_r <= rq_s3;
      // pub_r changes only after the serial side took the last value
      if ((pk_s2 == pub_tgl_r) && (pub_r != stat_w)) begin
        pub_r <= stat_w;
        pub_tgl_r <= ~pub_tgl_r;
      end
    end
  end

  assign quad_io_en = qe_r;
  assign secreg_ro = lb_r;
  assign nv_store = nv_store_r;
  assign nv_data = nv_data_r;
  assign op_start = op_start_r;
  assign op_req = op_req_r;
  assign op_suspend = op_susp_r;
  assign op_resume = op_res_r;
  assign op_abort = op_abort_r;

  // Helper count of cycles spent in a status write, so the busy time can be
  // checked exactly without a long delay range
  logic [11:0] srw_len_r;
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) srw_len_r <= 12'h000;
    else if (state_r == FSW_SRWR) srw_len_r <= srw_len_r + 12'h001;
    else srw_len_r <= 12'h000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync);

  chk_wip_start: assert property (op_start_r |-> stat_w[FSW_WIP] && state_r == FSW_ARRAY)
    else $error("busy bit not set with array start");
  chk_srw_ends: assert property ($fell(state_r == FSW_SRWR) |-> srw_len_r == FSW_SRW_CNT)
    else $error("status write busy time wrong");
  chk_srw_bound: assert property (state_r == FSW_SRWR |-> srw_len_r < FSW_SRW_CNT)
    else $error("status write busy too long");
  chk_wel_refuse: assert property (cmd_new && !wel_r |=> !op_start_r && state_r != FSW_SRWR)
    else $error("write accepted without latch");
  chk_bp_source: assert property (nv_ld_r && $changed(bp_r) |-> $past(do_write_status_cmd))
    else $error("protect field changed outside status write");
  chk_hw_lock: assert property (cmd_new && is_write_status_cmd && hw_lock |=> $stable(bp_r))
    else $error("protect field written under hardware lock");
  chk_prot_block: assert property (op_start_r && op_req_r.kind == FSW_OP_PROG
    |-> !prot_hit(op_req_r.addr[22:0], bp_r, cmp_r))
    else $error("program started in protected region");
  chk_chip_gate: assert property (op_start_r && op_req_r.kind == FSW_OP_CHIP |-> chip_ok)
    else $error("chip erase with protection set");
  chk_srp_lock: assert property (cmd_new && is_write_status_cmd && status_lock_sel_hi_r |=> $stable({bp_r, cmp_r, qe_r}))
    else $error("status written while locked");
  chk_lb_otp: assert property (nv_ld_r |=> ($past(lb_r) & ~lb_r) == 3'h0)
    else $error("security lock bit cleared");
  chk_sus_set: assert property (do_susp && susp_prog |=> psus_r && !esus_r [*2])
    else $error("program suspend flag wrong");
  chk_sus_clear: assert property (do_res |=> !psus_r && !esus_r && state_r == FSW_ARRAY)
    else $error("resume left suspend flag set");
  chk_wel_set: assert property (cmd_new && fmt_ok && code == FSW_C_SET_WRITE_LATCH_CMD && !busy |=> wel_r)
    else $error("write latch not set");
  cov_array_op: cover property (do_array ##[1:50] op_done);
  cov_srw: cover property (do_write_status_cmd ##1 state_r == FSW_SRWR);
  cov_suspend: cover property (do_susp ##[1:100] do_res);
  cov_blocked: cover property (take_wr && is_array && blocked);
endmodule // fsw_status_protect

// ==== sim/fsw_host_model.sv ====
module fsw_host_model (
  // Serial link toward the flash
  output logic sclk,
  output logic cmd_strobe,
  output fsw_pkg::fsw_cmd_t cmd,
  // Status readback
  input wire logic [15:0] status_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  import fsw_pkg::*;
  localparam int HALF_NS = 80;

  initial begin
    sclk = 1'b0;
    cmd_strobe = 1'b0;
    cmd = '0;
  end

  // Clock only runs inside frames and idles low between them
  task automatic run(input int n);
    repeat (n) begin
      #HALF_NS sclk = 1'b1;
      #HALF_NS sclk = 1'b0;
    end
  endtask

  // Shift-in time, one decoded-command cycle, then eight spacing cycles
  task automatic send(input logic [7:0] code, input logic [23:0] addr, input logic [7:0] lo,
      input logic [7:0] hi, input logic two, input logic ok);
    #7;
    run(8);
    cmd = '{code, addr, lo, hi, two, ok};
    cmd_strobe = 1'b1;
    run(1);
    cmd_strobe = 1'b0;
    // Released lines show a changed pattern, never the stale command
    cmd = ~cmd;
    run(8);
  endtask

  // Long enough for the core change to be published back on the link side
  task automatic read(output logic [15:0] s);
    #7;
    run(12);
    s = status_rd;
  endtask
endmodule // fsw_host_model

// ==== sim/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fsw_pkg::*;
  localparam int LIMIT = 90000;
  logic clk, rst_n, sclk, cmd_strobe, write_protect_n, quad_io_en, nv_store;
  logic op_start, op_suspend, op_resume, op_abort, op_done, susp;
  logic [15:0] status_rd, nv_image, nv_data, st;
  logic [2:0] secreg_ro;
  fsw_cmd_t cmd;
  fsw_op_t op_req;
  int errors = 0, checked = 0, cycles = 0, starts = 0, aborts = 0, done_dly = 20, run_cnt = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  fsw_status_protect i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cmd_strobe(cmd_strobe),
    .cmd(cmd), .status_rd(status_rd), .write_protect_n(write_protect_n),
    .quad_io_en(quad_io_en), .nv_image(nv_image), .nv_store(nv_store), .nv_data(nv_data),
    .op_start(op_start), .op_req(op_req), .op_suspend(op_suspend), .op_resume(op_resume),
    .op_abort(op_abort), .op_done(op_done), .secreg_ro(secreg_ro));

  fsw_host_model i_host (.sclk(sclk), .cmd_strobe(cmd_strobe), .cmd(cmd),
    .status_rd(status_rd));

  // Array datapath stand-in; its countdown freezes while the op is suspended
  always @(negedge clk) begin
    op_done <= 1'b0;
    if (op_start) begin
      starts <= starts + 1;
      run_cnt <= done_dly;
    end else if (op_suspend) begin
      susp <= 1'b1;
    end else if (op_resume) begin
      susp <= 1'b0;
    end else if (op_abort) begin
      aborts <= aborts + 1;
      run_cnt <= 0;
      susp <= 1'b0;
    end else if (run_cnt > 0 && !susp) begin
      run_cnt <= run_cnt - 1;
      op_done <= (run_cnt == 1);
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cmdx(input logic [7:0] code, input logic [23:0] addr = '0,
      input logic [7:0] lo = '0, input logic [7:0] hi = '0, input logic two = 1'b0);
    i_host.send(code, addr, lo, hi, two, 1'b1);
  endtask

  task automatic rdst(input logic [15:0] exp);
    i_host.read(st);
    check("status", 24'(st), 24'(exp));
  endtask

  // Power cycle: sclk must tick while reset is low
  task automatic pwr(input logic [15:0] img);
    @(negedge clk);
    nv_image = img;
    rst_n = 1'b0;
    fork
      i_host.run(2);
      repeat (16) @(negedge clk);
    join
    @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic write_status_cmd(input logic [7:0] lo, input logic [7:0] hi, input logic ok,
      input logic [15:0] exp);
    logic got;
    cmdx(FSW_C_SET_WRITE_LATCH_CMD);
    cmdx(FSW_C_WRITE_STATUS_CMD, 24'h0, lo, hi, 1'b1);
    i_host.read(st);
    check("busy", 24'(st[0]), 24'(ok));
    got = 1'b0;
    for (int n = 0; n < 1500 && !got; n++) begin
      @(negedge clk);
      got = nv_store;
    end
    check("store", 24'(got), 24'(ok));
    if (ok) check("nv_data", 24'(nv_data & 16'h7bfc), 24'(exp & 16'h7bfc));
    rdst(exp);
  endtask

  task automatic prog(input logic [7:0] code, input fsw_op_kind_t kind, input logic [23:0] addr,
      input logic ok);
    int s0;
    s0 = starts;
    cmdx(FSW_C_SET_WRITE_LATCH_CMD);
    cmdx(code, addr, 8'h5a);
    check("op_start", 24'(starts - s0), 24'(ok));
    if (ok) check("op_kind", 24'(kind), 24'(op_req.kind));
    if (ok && kind == FSW_OP_PROG) check("op_addr", op_req.addr, addr);
    i_host.read(st);
    check("wel", 24'(st[1]), 24'h0);
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 8000 && run_cnt != 0; n++) @(negedge clk);
    check("idle", 24'(run_cnt), 24'h0);
  endtask

  initial begin
    int a0;
    rst_n = 1'b0;
    write_protect_n = 1'b1;
    nv_image = 16'h0100;
    susp = 1'b0;
    op_done = 1'b0;
    pwr(16'h0100);
    rdst(16'h0000);
    check("quad", 24'(quad_io_en), 24'h0);
    check("secreg", 24'(secreg_ro), 24'h0);
    cmdx(FSW_C_WRITE_STATUS_CMD, 24'h0, 8'h04, 8'h00, 1'b1);
    rdst(16'h0000);
    cmdx(FSW_C_SET_WRITE_LATCH_CMD);
    rdst(16'h0002);
    cmdx(FSW_C_CLEAR_WRITE_LATCH_CMD);
    rdst(16'h0000);
    write_status_cmd(8'h05, 8'h8e, 1'b1, 16'h0a04);
    check("quad", 24'(quad_io_en), 24'h1);
    check("secreg", 24'(secreg_ro), 24'h1);
    @(negedge clk);
    write_protect_n = 1'b0;
    // Quad enable cleared again before the protect pin is leaned on
    write_status_cmd(8'h04, 8'h00, 1'b1, 16'h0804);
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h7e0000, 1'b0);
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h7dffff, 1'b1);
    prog(FSW_C_BLK64, FSW_OP_BLK64, 24'h7e0000, 1'b0);
    prog(FSW_C_BLK32, FSW_OP_BLK32, 24'h7d0000, 1'b1);
    write_status_cmd(8'h44, 8'h40, 1'b1, 16'h4844);
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h7fefff, 1'b0);
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h7ff000, 1'b1);
    write_status_cmd(8'h64, 8'h40, 1'b1, 16'h4864);
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h001000, 1'b0);
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h000fff, 1'b1);
    write_status_cmd(8'h60, 8'h40, 1'b1, 16'h4860);
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h7fffff, 1'b0);
    prog(FSW_C_CHIP1, FSW_OP_CHIP, 24'h0, 1'b0);
    write_status_cmd(8'h1c, 8'h40, 1'b1, 16'h481c);
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h000000, 1'b1);
    prog(FSW_C_CHIP1, FSW_OP_CHIP, 24'h0, 1'b1);
    write_status_cmd(8'h1c, 8'h00, 1'b1, 16'h081c);
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h400000, 1'b0);
    prog(FSW_C_CHIP2, FSW_OP_CHIP, 24'h0, 1'b0);
    prog(FSW_C_SECT, FSW_OP_SECT, 24'h000000, 1'b0);
    write_status_cmd(8'h00, 8'h00, 1'b1, 16'h0800);
    prog(FSW_C_CHIP2, FSW_OP_CHIP, 24'h0, 1'b1);
    done_dly = 3000;
    prog(FSW_C_PROG, FSW_OP_PROG, 24'h000100, 1'b1);
    rdst(16'h0801);
    cmdx(FSW_C_SUSP);
    rdst(16'h0c00);
    cmdx(FSW_C_RESUME);
    rdst(16'h0801);
    wait_idle();
    rdst(16'h0800);
    prog(FSW_C_SECT, FSW_OP_SECT, 24'h003000, 1'b1);
    cmdx(FSW_C_SUSP);
    rdst(16'h8800);
    a0 = aborts;
    cmdx(FSW_C_RSTEN);
    cmdx(FSW_C_RST);
    rdst(16'h0800);
    check("abort", 24'(aborts - a0), 24'h1);
    done_dly = 20;
    write_status_cmd(8'h80, 8'h00, 1'b1, 16'h0880);
    write_status_cmd(8'h84, 8'h00, 1'b0, 16'h0880);
    @(negedge clk);
    write_protect_n = 1'b1;
    write_status_cmd(8'h84, 8'h00, 1'b1, 16'h0884);
    write_status_cmd(8'h00, 8'h01, 1'b1, 16'h0900);
    write_status_cmd(8'h04, 8'h00, 1'b0, 16'h0900);
    pwr(nv_data);
    rdst(16'h0800);
    write_status_cmd(8'h80, 8'h01, 1'b1, 16'h0980);
    write_status_cmd(8'h04, 8'h00, 1'b0, 16'h0980);
    pwr(nv_data);
    write_status_cmd(8'h04, 8'h00, 1'b0, 16'h0980);
    end_sim();
  end
endmodule // tb
